// ### hdl/portb_ctl_pkg.sv
/*
 * constants for the port b control block: register offsets, field positions,
 * reset values and carrier timing.
 * assumes the core addresses control registers by an 8-bit index.
 */
package portb_ctl_pkg;
    // control register offsets
    localparam logic [7:0] OFS_DIR = 8'hF6;
    localparam logic [7:0] OFS_CHG_EN = 8'hF9;
    localparam logic [7:0] OFS_PD_OFF = 8'hFB;
    localparam logic [7:0] OFS_OD_ON = 8'hFC;
    localparam logic [7:0] OFS_PU_OFF = 8'hFD;
    localparam logic [7:0] OFS_SYS = 8'hFE;
    localparam logic [7:0] OFS_IMASK = 8'hFF;
    // special register indices
    localparam logic [7:0] OFS_IR = 8'h06;
    // reset values
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_CHG_EN = 8'hFF;
    localparam logic [7:0] RST_PD_OFF = 8'hFF;
    localparam logic [7:0] RST_OD_ON = 8'h00;
    localparam logic [7:0] RST_PU_OFF = 8'hFF;
    localparam logic [7:0] RST_SYS = 8'hA0;
    localparam logic [7:0] RST_IMASK = 8'h00;
    localparam logic [7:0] RST_TMODE = 8'h3F;
    localparam logic [7:0] RST_IR = 8'h00;
    // implemented bit masks
    localparam logic [7:0] SYS_MASK = 8'hEC;
    localparam logic [7:0] IMASK_MASK = 8'h47;
    localparam logic [7:0] IR_MASK = 8'h87;
    localparam logic [7:0] TMODE_WR_MASK = 8'hBF;
    // field positions
    localparam int SYS_SINK = 2;
    localparam int SYS_LPR = 3;
    localparam int SYS_LVR = 5;
    localparam int SYS_EXT = 6;
    localparam int SYS_WDT = 7;
    localparam int IM_T0 = 0;
    localparam int IM_PC = 1;
    localparam int IM_EX = 2;
    localparam int IM_WD = 6;
    localparam int TM_GIE = 6;
    localparam int TM_EDGE = 7;
    localparam int IR_EN = 0;
    localparam int IR_FSEL = 1;
    localparam int IR_POL = 2;
    localparam int IR_OSC = 7;
    localparam int PIN_EXT = 0;
    localparam int PIN_IR = 1;
    localparam int PIN_NOOPT = 3;
    localparam int HALF = 4;
    // carrier frequencies in hz and clock rate
    localparam int CLK_HZ = 50000000;
    localparam int CAR_LO_HZ = 38000;
    localparam int CAR_HI_HZ = 57000;
    // half periods in clock cycles, rounded down
    localparam int CAR_LO_HALF = CLK_HZ / (2 * CAR_LO_HZ);
    localparam int CAR_HI_HALF = CLK_HZ / (2 * CAR_HI_HZ);
endpackage : portb_ctl_pkg

// ### hdl/portb_carrier_if.sv
/*
 * interface between the control block and the carrier generator.
 * assumes both ends share one clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface portb_carrier_if;
    logic enable; // run the carrier
    logic fast; // 1 selects the higher frequency
    logic carrier; // square carrier level
    modport ctl (output enable, output fast, input carrier);
    modport gen (input enable, input fast, output carrier);
endinterface : portb_carrier_if
`default_nettype wire

// ### hdl/portb_carrier_gen.sv
/*
 * ir carrier square wave generator, two selectable frequencies.
 * assumes clock at the package rate.
 */
`timescale 1ns/1ns
`default_nettype none
module portb_carrier_gen
    import portb_ctl_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // control side
    portb_carrier_if.gen cif
);
    logic [15:0] cnt_q, cnt_d; // half period counter
    logic lvl_q, lvl_d; // carrier level
    logic [15:0] half_lim; // terminal count
    // next state of the divider
    always_comb begin
        half_lim = cif.fast ? 16'(CAR_HI_HALF - 1) : 16'(CAR_LO_HALF - 1);
        cnt_d = cnt_q + 16'h0001;
        lvl_d = lvl_q;
        if (!cif.enable) begin
            cnt_d = 16'h0000;
            lvl_d = 1'b0;
        end else if (cnt_q >= half_lim) begin
            cnt_d = 16'h0000;
            lvl_d = ~lvl_q;
        end
    end
    // divider registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_q <= 16'h0000;
            lvl_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            lvl_q <= lvl_d;
        end
    end
    assign cif.carrier = lvl_q;
endmodule : portb_carrier_gen
`default_nettype wire

// ### hdl/portb_ctl.sv
/*
 * port b pin control: direction, pulls, open drain, change and external
 * interrupt flags, system control, interrupt mask, ir carrier output.
 * assumes the core issues one-cycle register strobes on CLK.
 */
`timescale 1ns/1ns
`default_nettype none
module portb_ctl
    import portb_ctl_pkg::*;
#(
    parameter int W = 8 // port width
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // control register access
    input wire logic CR_WR,
    input wire logic CR_RD,
    input wire logic SF_WR,
    input wire logic [7:0] CR_ADDR,
    input wire logic [7:0] CR_WDATA,
    output logic [7:0] CR_RDATA,
    // timer mode register writes
    input wire logic TM_WR,
    // port data register
    input wire logic [W-1:0] PORT_DATA,
    output logic [W-1:0] PORT_PIN_LEVEL,
    // interrupt instructions and status clears
    input wire logic IRQ_DISABLE,
    input wire logic IRQ_ENABLE,
    input wire logic IRQ_RETURN,
    input wire logic IRQ_TAKEN,
    input wire logic CFG_WDT_IRQ,
    input wire logic PC_FLAG_CLR,
    input wire logic EX_FLAG_CLR,
    // pins
    input wire logic [W-1:0] PIN_I,
    output logic [W-1:0] PIN_O,
    output logic [W-1:0] PIN_OE,
    output logic [W-1:0] PULLUP_EN,
    output logic [W-1:0] PULLDOWN_EN,
    // mode outputs
    output logic SINK_MODE,
    output logic LOW_POWER_RESET_EN,
    output logic LOW_VOLTAGE_RESET_EN,
    output logic WATCHDOG_EN,
    output logic [7:0] IRQ_MASK,
    output logic WDT_IRQ_EN,
    output logic [7:0] TIMER_MODE,
    output logic PORT_CHANGE_FLAG,
    output logic EXT_IRQ_FLAG
);
    // register state
    logic [W-1:0] dir_q, dir_d; // 1 input
    logic [W-1:0] chg_en_q, chg_en_d; // change enables
    logic [W-1:0] pd_off_q, pd_off_d; // pull-down disables
    logic [W-1:0] od_on_q, od_on_d; // open drain enables
    logic [W-1:0] pu_off_q, pu_off_d; // pull-up disables
    logic [7:0] sys_q, sys_d; // system control
    logic [7:0] imask_q, imask_d; // interrupt mask
    logic [7:0] tmode_q, tmode_d; // timer mode
    logic [7:0] ir_q, ir_d; // ir control, write only
    logic [7:0] rdata_q, rdata_d; // read data
    // pin sampling
    logic [W-1:0] sync1_q, sync2_q; // two-stage synchroniser
    logic [W-1:0] last_q; // previously latched pins
    logic pcf_q, pcf_d; // port change flag
    logic exf_q, exf_d; // external flag
    // output stage
    logic [W-1:0] pin_o_q, pin_o_d;
    logic [W-1:0] pin_oe_q, pin_oe_d;
    logic [W-1:0] pu_q, pu_d;
    logic [W-1:0] pdn_q, pdn_d;
    logic sink_q, sink_d;
    logic watchdog_irq_enable_q, watchdog_irq_enable_d;
    logic [W-1:0] lvl_q;
    // misc
    logic ext_mode; // external irq mode
    logic [W-1:0] chg_arm; // effective change enables
    logic edge_hit; // selected edge on pin0
    logic ir_on; // ir carrier mode
    logic ir_bit; // modulated pin1 level
    portb_carrier_if cif ();

    // carrier generator
    portb_carrier_gen u_carrier (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .cif(cif)
    );
    assign cif.enable = ir_q[IR_EN];
    assign cif.fast = ir_q[IR_FSEL];

    // register writes and reads
    always_comb begin
        dir_d = dir_q;
        chg_en_d = chg_en_q;
        pd_off_d = pd_off_q;
        od_on_d = od_on_q;
        pu_off_d = pu_off_q;
        sys_d = sys_q;
        imask_d = imask_q;
        tmode_d = tmode_q;
        ir_d = ir_q;
        rdata_d = rdata_q;
        if (CR_WR) begin
            case (CR_ADDR)
                OFS_DIR: dir_d = CR_WDATA[W-1:0];
                OFS_CHG_EN: chg_en_d = CR_WDATA[W-1:0];
                OFS_PD_OFF: pd_off_d = CR_WDATA[W-1:0];
                OFS_OD_ON: od_on_d = CR_WDATA[W-1:0];
                OFS_PU_OFF: pu_off_d = CR_WDATA[W-1:0];
                OFS_SYS: sys_d = CR_WDATA & SYS_MASK;
                OFS_IMASK: imask_d = CR_WDATA & IMASK_MASK;
                default: ;
            endcase
        end
        // ir register reached only by special writes
        if (SF_WR && CR_ADDR == OFS_IR) begin
            ir_d = CR_WDATA & IR_MASK;
        end
        // edge select and prescaler writable, flag bit kept
        if (TM_WR) begin
            tmode_d = (CR_WDATA & TMODE_WR_MASK) | (tmode_q & ~TMODE_WR_MASK);
        end
        // global enable driven only by instruction events
        if (IRQ_DISABLE || IRQ_TAKEN) begin
            tmode_d[TM_GIE] = 1'b0;
        end else if (IRQ_ENABLE || IRQ_RETURN) begin
            tmode_d[TM_GIE] = 1'b1;
        end
        if (CR_RD) begin
            case (CR_ADDR)
                OFS_DIR: rdata_d = 8'(dir_q);
                OFS_CHG_EN: rdata_d = 8'(chg_en_q);
                OFS_PD_OFF: rdata_d = 8'(pd_off_q);
                OFS_OD_ON: rdata_d = 8'(od_on_q);
                OFS_PU_OFF: rdata_d = 8'(pu_off_q);
                OFS_SYS: rdata_d = sys_q;
                OFS_IMASK: rdata_d = imask_q;
                default: rdata_d = 8'h00; // ir and unknown read zero
            endcase
        end
    end

    // register file flops
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dir_q <= W'(RST_DIR);
            chg_en_q <= W'(RST_CHG_EN);
            pd_off_q <= W'(RST_PD_OFF);
            od_on_q <= W'(RST_OD_ON);
            pu_off_q <= W'(RST_PU_OFF);
            sys_q <= RST_SYS;
            imask_q <= RST_IMASK;
            tmode_q <= RST_TMODE;
            ir_q <= RST_IR;
            rdata_q <= 8'h00;
        end else begin
            dir_q <= dir_d;
            chg_en_q <= chg_en_d;
            pd_off_q <= pd_off_d;
            od_on_q <= od_on_d;
            pu_off_q <= pu_off_d;
            sys_q <= sys_d;
            imask_q <= imask_d;
            tmode_q <= tmode_d;
            ir_q <= ir_d;
            rdata_q <= rdata_d;
        end
    end

    // pin synchroniser and change latch
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1_q <= '0;
            sync2_q <= '0;
            last_q <= '0;
            lvl_q <= '0;
        end else begin
            sync1_q <= PIN_I;
            sync2_q <= sync1_q;
            last_q <= sync2_q;
            lvl_q <= sync2_q; // pin0 stays readable in ext mode
        end
    end

    assign ext_mode = sys_q[SYS_EXT];
    assign ir_on = ir_q[IR_EN];
    // edge on pin0 per edge select
    assign edge_hit = tmode_q[TM_EDGE] ? (sync2_q[PIN_EXT] & ~last_q[PIN_EXT])
                                       : (~sync2_q[PIN_EXT] & last_q[PIN_EXT]);
    // polarity: 0 carrier on high data, 1 on low data
    assign ir_bit = (PORT_DATA[PIN_IR] ^ ir_q[IR_POL]) & cif.carrier;

    // per-pin enables and drive
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_pin
            always_comb begin
                chg_arm[gi] = chg_en_q[gi];
                if (gi == PIN_EXT && ext_mode) begin
                    chg_arm[gi] = 1'b0;
                end
                pin_oe_d[gi] = ~dir_q[gi];
                pin_o_d[gi] = PORT_DATA[gi];
                if (gi == PIN_EXT && ext_mode) begin
                    pin_oe_d[gi] = 1'b0;
                end
                if (gi == PIN_IR && ir_on) begin
                    pin_oe_d[gi] = 1'b1;
                    pin_o_d[gi] = ir_bit;
                end
                if (gi != PIN_NOOPT && od_on_q[gi]) begin
                    // open drain drives only low
                    pin_oe_d[gi] = pin_oe_d[gi] & ~pin_o_d[gi];
                end
                pu_d[gi] = (gi != PIN_NOOPT) && !pu_off_q[gi];
                pdn_d[gi] = !pd_off_q[(gi + HALF) % W];
            end
        end
    endgenerate

    // sticky flags, set wins over clear
    always_comb begin
        pcf_d = pcf_q;
        exf_d = exf_q;
        if (PC_FLAG_CLR) begin
            pcf_d = 1'b0;
        end
        if (|((sync2_q ^ last_q) & chg_arm)) begin
            pcf_d = 1'b1;
        end
        if (EX_FLAG_CLR) begin
            exf_d = 1'b0;
        end
        if (ext_mode && edge_hit) begin
            exf_d = 1'b1;
        end
        // follows the direction bit, so an open-drain pin idling high keeps the mode
        sink_d = sys_q[SYS_SINK] && (!dir_q[PIN_IR] || ir_on);
        watchdog_irq_enable_d = imask_q[IM_WD] && CFG_WDT_IRQ;
    end

    // output stage flops
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pcf_q <= 1'b0;
            exf_q <= 1'b0;
            pin_o_q <= '0;
            pin_oe_q <= '0;
            pu_q <= '0;
            pdn_q <= '0;
            sink_q <= 1'b0;
            watchdog_irq_enable_q <= 1'b0;
        end else begin
            pcf_q <= pcf_d;
            exf_q <= exf_d;
            pin_o_q <= pin_o_d;
            pin_oe_q <= pin_oe_d;
            pu_q <= pu_d;
            pdn_q <= pdn_d;
            sink_q <= sink_d;
            watchdog_irq_enable_q <= watchdog_irq_enable_d;
        end
    end

    assign CR_RDATA = rdata_q;
    assign PORT_PIN_LEVEL = lvl_q;
    assign PIN_O = pin_o_q;
    assign PIN_OE = pin_oe_q;
    assign PULLUP_EN = pu_q;
    assign PULLDOWN_EN = pdn_q;
    assign SINK_MODE = sink_q;
    assign LOW_POWER_RESET_EN = sys_q[SYS_LPR];
    assign LOW_VOLTAGE_RESET_EN = sys_q[SYS_LVR];
    assign WATCHDOG_EN = sys_q[SYS_WDT];
    assign IRQ_MASK = imask_q;
    assign WDT_IRQ_EN = watchdog_irq_enable_q;
    assign TIMER_MODE = tmode_q;
    assign PORT_CHANGE_FLAG = pcf_q;
    assign EXT_IRQ_FLAG = exf_q;

    // assertions
    property p_dir_oe;
        @(posedge CLK) disable iff (!ARST_N)
        (!ir_on && !sys_q[SYS_EXT] && !od_on_q[2]) |=> (PIN_OE[2] == ~$past(dir_q[2]));
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("direction not applied");
    property p_chg_flag;
        @(posedge CLK) disable iff (!ARST_N)
        (|((sync2_q ^ last_q) & chg_arm)) |=> PORT_CHANGE_FLAG;
    endproperty
    a_chg_flag: assert property (p_chg_flag) else $error("change flag missed");
    property p_ext_no_chg;
        @(posedge CLK) disable iff (!ARST_N)
        ext_mode |-> !chg_arm[PIN_EXT];
    endproperty
    a_ext_no_chg: assert property (p_ext_no_chg) else $error("pin0 change armed");
    property p_pd_swap;
        @(posedge CLK) disable iff (!ARST_N)
        1'b1 |=> (PULLDOWN_EN[0] == !$past(pd_off_q[HALF]));
    endproperty
    a_pd_swap: assert property (p_pd_swap) else $error("pulldown map wrong");
    property p_pu3;
        @(posedge CLK) disable iff (!ARST_N)
        !PULLUP_EN[PIN_NOOPT];
    endproperty
    a_pu3: assert property (p_pu3) else $error("pin3 pullup driven");
    property p_ir_oe;
        @(posedge CLK) disable iff (!ARST_N)
        (ir_on && !od_on_q[PIN_IR]) |=> PIN_OE[PIN_IR];
    endproperty
    a_ir_oe: assert property (p_ir_oe) else $error("ir pin not output");
    property p_gie_off;
        @(posedge CLK) disable iff (!ARST_N)
        (IRQ_DISABLE || IRQ_TAKEN) |=> !TIMER_MODE[TM_GIE];
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("gie not cleared");
    property p_ext_flag;
        @(posedge CLK) disable iff (!ARST_N)
        (ext_mode && edge_hit) |=> EXT_IRQ_FLAG;
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("ext flag missed");
    // option absent for two cycles running
    sequence s_no_wdt_opt;
        !CFG_WDT_IRQ ##1 !CFG_WDT_IRQ;
    endsequence
    property p_watchdog_irq_enable;
        @(posedge CLK) disable iff (!ARST_N)
        s_no_wdt_opt |-> !WDT_IRQ_EN;
    endproperty
    a_watchdog_irq_enable: assert property (p_watchdog_irq_enable) else $error("wdt irq without option");
    property p_ir_read;
        @(posedge CLK) disable iff (!ARST_N)
        (CR_RD && CR_ADDR == OFS_IR) |=> (CR_RDATA == 8'h00);
    endproperty
    a_ir_read: assert property (p_ir_read) else $error("ir register readable");
endmodule : portb_ctl
`default_nettype wire

// ### test/portb_pins_model.sv
/*
 * model of the circuitry outside the eight port pins: external drivers,
 * the device's own drive and pulls, and a wandering level on open pins.
 * assumes the bench sets the external drive on the clock's rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
module portb_pins_model #(
    parameter int W = 8 // port width
) (
    // clock
    input wire logic CLK,
    // device pin side
    input wire logic [W-1:0] PIN_O,
    input wire logic [W-1:0] PIN_OE,
    input wire logic [W-1:0] PULLUP_EN,
    input wire logic [W-1:0] PULLDOWN_EN,
    // external drivers
    input wire logic [W-1:0] EXT_EN,
    input wire logic [W-1:0] EXT_VAL,
    // resolved wire levels
    output logic [W-1:0] PIN_I
);
    logic [W-1:0] float_q = '0; // level of an undriven, unpulled pin

    // an open pin changes every cycle so a stale value never passes
    always @(posedge CLK) begin
        float_q <= ~float_q;
    end

    // device drive wins, then outside drive, then the pulls
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (PIN_OE[i]) begin
                PIN_I[i] = PIN_O[i];
            end else if (EXT_EN[i]) begin
                PIN_I[i] = EXT_VAL[i];
            end else if (PULLUP_EN[i]) begin
                PIN_I[i] = 1'b1;
            end else if (PULLDOWN_EN[i]) begin
                PIN_I[i] = 1'b0;
            end else begin
                PIN_I[i] = float_q[i];
            end
        end
    end
endmodule : portb_pins_model
`default_nettype wire

// ### test/tb.sv
/*
 * self-checking bench for the port b control block.
 * assumes the pin model on the far side and the package constants.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import portb_ctl_pkg::*;
    localparam int LIMIT = 20000; // cycle ceiling for a hang
    logic clk = 1'b0; // 50 mhz clock
    logic arst_n = 1'b0; // reset, active low
    logic [9:0] stb = '0; // strobes: wr rd sf tm dis en ret taken pcclr exclr
    logic [7:0] cr_addr = '0;
    logic [7:0] cr_wdata = '0;
    logic [7:0] port_data = 8'h0F; // core port data register
    logic cfg_wdt = 1'b0; // config word watchdog irq option
    logic [7:0] ext_en = 8'hFF; // outside drive enables
    logic [7:0] ext_val = '0; // outside drive levels
    logic [7:0] cr_rdata, pin_level, pin_i, pin_o, pin_oe, pu_en, pd_en, irq_mask, tmode;
    logic sink, lpr, lvr, wdt_en, wdt_irq_en, pc_flag, ex_flag;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    int slow_n, fast_n;
    logic [7:0] ofs [7] = '{OFS_DIR, OFS_CHG_EN, OFS_PD_OFF, OFS_OD_ON, OFS_PU_OFF, OFS_SYS,
        OFS_IMASK};
    logic [7:0] rst [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hA0, 8'h00};
    logic [7:0] msk [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hEC, 8'h47};
    int ist [4] = '{5, 4, 6, 7}; // enable, disable, return, taken

    always #10 clk = ~clk;

    portb_ctl dut (.CLK(clk), .ARST_N(arst_n), .CR_WR(stb[0]), .CR_RD(stb[1]),
        .SF_WR(stb[2]), .CR_ADDR(cr_addr), .CR_WDATA(cr_wdata), .CR_RDATA(cr_rdata),
        .TM_WR(stb[3]), .PORT_DATA(port_data), .PORT_PIN_LEVEL(pin_level),
        .IRQ_DISABLE(stb[4]), .IRQ_ENABLE(stb[5]), .IRQ_RETURN(stb[6]), .IRQ_TAKEN(stb[7]),
        .CFG_WDT_IRQ(cfg_wdt), .PC_FLAG_CLR(stb[8]), .EX_FLAG_CLR(stb[9]), .PIN_I(pin_i),
        .PIN_O(pin_o), .PIN_OE(pin_oe), .PULLUP_EN(pu_en), .PULLDOWN_EN(pd_en),
        .SINK_MODE(sink), .LOW_POWER_RESET_EN(lpr), .LOW_VOLTAGE_RESET_EN(lvr),
        .WATCHDOG_EN(wdt_en), .IRQ_MASK(irq_mask), .WDT_IRQ_EN(wdt_irq_en),
        .TIMER_MODE(tmode), .PORT_CHANGE_FLAG(pc_flag), .EXT_IRQ_FLAG(ex_flag));

    portb_pins_model #(.W(8)) pins (.CLK(clk), .PIN_O(pin_o), .PIN_OE(pin_oe),
        .PULLUP_EN(pu_en), .PULLDOWN_EN(pd_en), .EXT_EN(ext_en), .EXT_VAL(ext_val),
        .PIN_I(pin_i));

    // counts and verdict, the only place the run ends
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // one comparison
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // one-cycle strobe s with address and data, taken at the second edge
    task automatic pulse(input int s, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        stb[s] <= 1'b1;
        cr_addr <= a;
        cr_wdata <= d;
        @(posedge clk);
        stb <= '0;
    endtask : pulse

    // read a control register and compare
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        pulse(1, a, 8'h00);
        @(posedge clk);
        @(negedge clk);
        check(cr_rdata, exp);
    endtask : rd_chk

    // let register and pin outputs land
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // count changes of the ir pin over n cycles
    task automatic count_edges(input int n, output int c);
        logic last;
        c = 0;
        @(negedge clk);
        last = pin_o[PIN_IR];
        repeat (n) begin
            @(negedge clk);
            if (pin_o[PIN_IR] !== last) c++;
            last = pin_o[PIN_IR];
        end
    endtask : count_edges

    task automatic end_test(input string name);
        $display("test %0s done", name);
    endtask : end_test

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        settle(3);
        // reset state of outputs
        check(pu_en, 8'h00);
        check(pd_en | pin_oe, 8'h00);
        check(tmode, 8'h3F);
        check({5'h00, wdt_en, lvr, lpr}, 8'h06);
        // reset values, write and read back, unused bits
        for (int i = 0; i < 7; i++) begin
            rd_chk(ofs[i], rst[i]);
            pulse(0, ofs[i], 8'h5A);
            rd_chk(ofs[i], 8'h5A & msk[i]);
            pulse(0, ofs[i], rst[i]);
        end
        rd_chk(8'h10, 8'h00); // unmapped place reads zero
        end_test("registers");
        // direction and open drain
        @(posedge clk);
        ext_en <= 8'h00;
        pulse(0, OFS_DIR, 8'h00);
        settle(3);
        check(pin_oe, 8'hFF);
        check(pin_o, 8'h0F);
        pulse(0, OFS_OD_ON, 8'hFF);
        settle(3);
        check(pin_oe, 8'hF8);
        pulse(0, OFS_OD_ON, 8'h00);
        pulse(0, OFS_DIR, 8'hFF);
        ext_en <= 8'hFF;
        settle(3);
        check(pin_oe, 8'h00);
        end_test("direction");
        // pulls, active low, nibble-swapped pulldowns
        pulse(0, OFS_PU_OFF, 8'h00);
        settle(3);
        check(pu_en, 8'hF7);
        pulse(0, OFS_PU_OFF, 8'hFF);
        pulse(0, OFS_PD_OFF, 8'hFE);
        settle(3);
        check(pd_en, 8'h10);
        pulse(0, OFS_PD_OFF, 8'hEF);
        settle(3);
        check(pd_en, 8'h01);
        pulse(0, OFS_PD_OFF, 8'hFF);
        end_test("pulls");
        // system control: sink mode only with pin 1 as output or the ir carrier on
        pulse(0, OFS_SYS, 8'h2C);
        settle(3);
        check({4'h0, sink, wdt_en, lvr, lpr}, 8'h03);
        pulse(0, OFS_DIR, 8'hFD);
        settle(3);
        check({7'h00, sink}, 8'h01);
        pulse(0, OFS_DIR, 8'hFF);
        pulse(0, OFS_SYS, 8'hA0);
        settle(3);
        check({4'h0, sink, wdt_en, lvr, lpr}, 8'h06);
        end_test("system");
        // interrupt mask and watchdog option
        pulse(0, OFS_IMASK, 8'hFF);
        settle(3);
        check(irq_mask, 8'h47);
        check({7'h00, wdt_irq_en}, 8'h00);
        @(posedge clk);
        cfg_wdt <= 1'b1;
        settle(3);
        check({7'h00, wdt_irq_en}, 8'h01);
        pulse(0, OFS_IMASK, 8'h00);
        end_test("mask");
        // timer mode, global enable flag driven only by instructions
        pulse(3, 8'h00, 8'hFF);
        settle(1);
        check(tmode, 8'hBF);
        for (int i = 0; i < 4; i++) begin
            pulse(ist[i], 8'h00, 8'h00);
            settle(1);
            check(tmode, 8'hBF | ((ist[i] == 5 || ist[i] == 6) ? 8'h40 : 8'h00));
        end
        end_test("timer mode");
        // external pin interrupt, rising edge first; pin 0 already an input
        pulse(0, OFS_DIR, 8'hFF);
        pulse(0, OFS_SYS, 8'hE0);
        pulse(9, 8'h00, 8'h00);
        pulse(8, 8'h00, 8'h00);
        @(posedge clk);
        ext_val <= 8'h01;
        settle(8);
        check({pin_level[0], pc_flag, ex_flag}, 8'h05);
        pulse(9, 8'h00, 8'h00);
        @(posedge clk);
        ext_val <= 8'h00;
        settle(8);
        check({7'h00, ex_flag}, 8'h00);
        pulse(3, 8'h00, 8'h3F);
        @(posedge clk);
        ext_val <= 8'h01;
        settle(8);
        check({7'h00, ex_flag}, 8'h00);
        @(posedge clk);
        ext_val <= 8'h00;
        settle(8);
        check({6'h00, pc_flag, ex_flag}, 8'h01);
        pulse(0, OFS_SYS, 8'hA0);
        end_test("external");
        // pin change flag, per-pin enable, sticky until cleared
        pulse(0, OFS_CHG_EN, 8'hDF);
        pulse(8, 8'h00, 8'h00);
        @(posedge clk);
        ext_val <= 8'h20;
        settle(8);
        check({7'h00, pc_flag}, 8'h00);
        pulse(0, OFS_CHG_EN, 8'hFF);
        @(posedge clk);
        ext_val <= 8'h00;
        settle(20);
        check({7'h00, pc_flag}, 8'h01);
        pulse(8, 8'h00, 8'h00);
        settle(3);
        check({7'h00, pc_flag}, 8'h00);
        end_test("change");
        // ir carrier: forced output, slow then fast carrier, write only
        pulse(2, OFS_IR, 8'h01);
        settle(3);
        check({7'h00, pin_oe[PIN_IR]}, 8'h01);
        count_edges(4 * CAR_LO_HALF, slow_n);
        pulse(2, OFS_IR, 8'h83);
        count_edges(4 * CAR_LO_HALF, fast_n);
        check({7'h00, slow_n >= 3}, 8'h01);
        check({7'h00, fast_n > slow_n}, 8'h01);
        // carrier on low data: high data gives a quiet pin, low data a carrier
        pulse(2, OFS_IR, 8'h05);
        settle(2);
        count_edges(4 * CAR_HI_HALF, fast_n);
        check(fast_n[7:0], 8'h00);
        @(posedge clk);
        port_data <= 8'h0D;
        count_edges(4 * CAR_LO_HALF, slow_n);
        check({7'h00, slow_n >= 3}, 8'h01);
        @(posedge clk);
        port_data <= 8'h0F;
        rd_chk(OFS_IR, 8'h00);
        pulse(2, OFS_IR, 8'h00);
        settle(3);
        check({7'h00, pin_oe[PIN_IR]}, 8'h00);
        end_test("carrier");
        complete_run();
    end
endmodule : tb
`default_nettype wire
